// ==== verilog/pif_defines.svh ====
/*
 * Register offsets, field positions, command codes and fixed memory
 * locations of the program interrupt facility.
 * Assumes an 8-bit AXI4-Lite byte address and 32-bit data words.
 */
`ifndef PIF_DEFINES_SVH
`define PIF_DEFINES_SVH

// Register byte offsets
`define PIF_ADDR_W      8
`define PIF_OFF_CTRL    8'h00
`define PIF_OFF_MASK    8'h04
`define PIF_OFF_ACK     8'h08
`define PIF_OFF_BRST    8'h0c
`define PIF_OFF_DONE    8'h10
`define PIF_OFF_BUSY    8'h14
`define PIF_OFF_REQ     8'h18

// Flag-control field of control, mask and bus-reset writes
`define PIF_F_HI        17
`define PIF_F_LO        16
`define PIF_F_START     2'h1
`define PIF_F_CLEAR     2'h2

// Accumulator image: bit 0 of the word is wdata[15]
`define PIF_ACC_MSB     15
`define PIF_CODE_W      6

// Interrupt entry locations
`define PIF_SAVE_LOC    16'h0000
`define PIF_JUMP_LOC    16'h0001

// Bus answers
`define PIF_RESP_OKAY   2'h0
`define PIF_RESP_SLVERR 2'h2

`endif

// ==== verilog/pif_pkg.sv ====
/*
 * Shared types of the program interrupt facility.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package pif_pkg;

	// Interrupt entry sequence
	typedef enum logic [1:0] {
		st_idle,
		st_save,
		st_jump
	} pif_seq_t;

endpackage : pif_pkg

// ==== verilog/pif_top.sv ====
/*
 * Program interrupt facility: interrupt-enable flag, per-peripheral
 * done, busy and mask flags, shared request line, daisy-chained
 * acknowledge and the interrupt entry sequence, with an AXI4-Lite slave.
 * Assumes the processor core and peripheral pulses share aclk.
 */
// Behaviour
// - Enable flag 1 accepts requests, 0 ignores
// - Start command sets enable, Clear clears it
// - Enable cleared at power-up and console reset
// - Each peripheral has mask; mask blocks request
// - Mask write loads all masks from accumulator
// - Masks cleared at power-up and console reset
// - Done set raises request, reaches processor unmasked
// - Masked request withheld until mask clears
// - All requests share one request line
// - Start only at boundary, enabled, request, no channel
// - Serve all data channel requests before interrupt
// - Clear enable, save PC at 0, jump via 1
// - Acknowledge returns code of first requester
// - Masked peripherals do not answer acknowledge
// - Done readback ignores the mask
// - Request stands while done is set
// - One instruction after enabling before next interrupt
// - Code in accumulator bits 10-15, zero if none
// - Bus reset clears flags, then applies flag control
`timescale 1ns/1ps
`include "pif_defines.svh"

module pif_top
	import pif_pkg::*;
#(
	parameter int                        N             = 4,
	parameter logic [N*`PIF_CODE_W-1:0] DEV_CODE_LIST = {6'h13, 6'h12, 6'h11, 6'h10},
	parameter logic [N*4-1:0]           MASK_BIT_LIST = {4'h3, 4'h2, 4'h1, 4'h0}
) (
	// Clock and reset
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	input  wire logic                   console_reset,
	// AXI4-Lite write
	input  wire logic [`PIF_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	output logic [1:0]                  s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	// AXI4-Lite read
	input  wire logic [`PIF_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	output logic [31:0]                 s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	// Peripheral side
	input  wire logic [N-1:0]           dev_done_set,
	input  wire logic [N-1:0]           dev_busy_set,
	output logic [N-1:0]                dev_done_flag,
	output logic [N-1:0]                dev_mask_flag,
	// Processor side
	input  wire logic                   insn_end,
	input  wire logic                   dch_pending,
	input  wire logic [15:0]            next_pc,
	output logic                        irq_request_line,
	output logic                        irq_start,
	output logic                        mem_we,
	output logic                        jump_indirect,
	output logic [15:0]                 mem_addr,
	output logic [15:0]                 mem_wdata
);

	typedef struct packed {
		logic           cpu_irq_enable_flag;
		logic           defer;
		logic [N-1:0]   done;
		logic [N-1:0]   busy;
		logic [N-1:0]   mask;
		logic           req_line;
		logic           boundary;
		pif_seq_t       seq;
		logic           start;
		logic           mem_we;
		logic           jump;
		logic [15:0]    mem_addr;
		logic [15:0]    mem_wdata;
		logic           bvalid;
		logic [1:0]     bresp;
		logic           rvalid;
		logic [1:0]     rresp;
		logic [31:0]    rdata;
	} pif_state_t;

	pif_state_t s_reg;
	pif_state_t s_next;

	logic [N-1:0]            req;
	logic [N-1:0]            mask_img;
	logic [N:0]              chain_blk;
	logic [N-1:0]            chain_hit;
	logic [`PIF_CODE_W-1:0]  code_or [0:N];
	logic [`PIF_CODE_W-1:0]  ack_code;
	logic                    wr_fire;
	logic                    rd_fire;
	logic [1:0]              wr_f;

	// Apply a flag-control field to the enable flag
	function automatic logic apply_f(input logic cur, input logic [1:0] f);
		logic r;
		r = cur;
		if (f == `PIF_F_START)
			r = 1'b1;
		else if (f == `PIF_F_CLEAR)
			r = 1'b0;
		return r;
	endfunction : apply_f

	// Unmasked done flags are the requests; a masked one just waits
	assign req = s_reg.done & ~s_reg.mask;

	// Per-peripheral mask bit and acknowledge daisy chain
	assign chain_blk[0] = 1'b0;
	assign code_or[0]   = '0;
	generate
		for (genvar i = 0; i < N; i++) begin : g_dev
			// Accumulator bit k sits at wdata[15-k]
			assign mask_img[i]    = s_axi_wdata[`PIF_ACC_MSB - MASK_BIT_LIST[i*4 +: 4]];
			assign chain_hit[i]   = req[i] & ~chain_blk[i];
			assign chain_blk[i+1] = chain_blk[i] | req[i];
			assign code_or[i+1]   = code_or[i] |
				({`PIF_CODE_W{chain_hit[i]}} & DEV_CODE_LIST[i*`PIF_CODE_W +: `PIF_CODE_W]);
		end
	endgenerate
	assign ack_code = code_or[N];

	// Write address and data are taken together, so arrival order is free
	assign wr_fire       = s_axi_awvalid & s_axi_wvalid & ~s_reg.bvalid;
	assign s_axi_awready = s_axi_wvalid & ~s_reg.bvalid;
	assign s_axi_wready  = s_axi_awvalid & ~s_reg.bvalid;
	assign rd_fire       = s_axi_arvalid & ~s_reg.rvalid;
	assign s_axi_arready = ~s_reg.rvalid;
	assign wr_f          = s_axi_wdata[`PIF_F_HI:`PIF_F_LO];

	// Next-state logic for the whole block
	always_comb begin
		s_next        = s_reg;
		s_next.start  = 1'b0;
		s_next.mem_we = 1'b0;
		s_next.jump   = 1'b0;

		// Bus answers retire on their ready
		if (s_reg.bvalid && s_axi_bready)
			s_next.bvalid = 1'b0;
		if (s_reg.rvalid && s_axi_rready)
			s_next.rvalid = 1'b0;

		// Register writes; an all-zero strobe still answers but changes nothing
		if (wr_fire) begin
			s_next.bvalid = 1'b1;
			s_next.bresp  = `PIF_RESP_OKAY;
			case (s_axi_awaddr)
				`PIF_OFF_CTRL: begin
					if (|s_axi_wstrb)
						s_next.cpu_irq_enable_flag = apply_f(s_reg.cpu_irq_enable_flag, wr_f);
				end
				`PIF_OFF_MASK: begin
					if (|s_axi_wstrb) begin
						s_next.mask = mask_img;
						s_next.cpu_irq_enable_flag  = apply_f(s_reg.cpu_irq_enable_flag, wr_f);
					end
				end
				`PIF_OFF_BRST: begin
					if (|s_axi_wstrb) begin
						s_next.busy = '0;
						s_next.done = '0;
						s_next.mask = '0;
						s_next.cpu_irq_enable_flag  = apply_f(s_reg.cpu_irq_enable_flag, wr_f);
					end
				end
				`PIF_OFF_DONE: begin
					if (|s_axi_wstrb)
						s_next.done = s_reg.done & ~s_axi_wdata[N-1:0];
				end
				`PIF_OFF_ACK, `PIF_OFF_BUSY, `PIF_OFF_REQ: begin
				end
				default: s_next.bresp = `PIF_RESP_SLVERR;
			endcase
		end

		// Console reset acts as a bus reset with the enable cleared
		if (console_reset) begin
			s_next.cpu_irq_enable_flag  = 1'b0;
			s_next.mask = '0;
			s_next.done = '0;
			s_next.busy = '0;
		end

		// Peripheral events come last so a set beats a same-cycle clear
		s_next.busy = (s_next.busy | dev_busy_set) & ~dev_done_set;
		s_next.done = s_next.done | dev_done_set;

		// Register reads; acknowledge has no side effect on the flags
		if (rd_fire) begin
			s_next.rvalid = 1'b1;
			s_next.rresp  = `PIF_RESP_OKAY;
			s_next.rdata  = '0;
			case (s_axi_araddr)
				`PIF_OFF_CTRL: s_next.rdata[1:0] = {s_reg.defer, s_reg.cpu_irq_enable_flag};
				`PIF_OFF_MASK: s_next.rdata[N-1:0] = s_reg.mask;
				`PIF_OFF_ACK:  s_next.rdata[`PIF_CODE_W-1:0] = ack_code;
				`PIF_OFF_DONE: s_next.rdata[N-1:0] = s_reg.done;
				`PIF_OFF_BUSY: s_next.rdata[N-1:0] = s_reg.busy;
				`PIF_OFF_REQ:  s_next.rdata[N-1:0] = req;
				`PIF_OFF_BRST: begin
				end
				default: s_next.rresp = `PIF_RESP_SLVERR;
			endcase
		end

		// One shared line, registered so it never glitches
		s_next.req_line = |req;

		// Interrupt entry: a boundary waits out every channel request
		unique case (s_reg.seq)
			st_idle: begin
				if (insn_end || s_reg.boundary) begin
					if (dch_pending) begin
						s_next.boundary = 1'b1;
					end else begin
						s_next.boundary = 1'b0;
						if (s_reg.defer) begin
							s_next.defer = 1'b0;
						end else if (s_reg.cpu_irq_enable_flag && (|req) && !console_reset) begin
							s_next.cpu_irq_enable_flag       = 1'b0;
							s_next.start     = 1'b1;
							s_next.mem_we    = 1'b1;
							s_next.mem_addr  = `PIF_SAVE_LOC;
							s_next.mem_wdata = next_pc;
							s_next.seq       = st_save;
						end
					end
				end
			end
			st_save: begin
				// Boundaries cannot arrive while the core is in entry
				s_next.jump     = 1'b1;
				s_next.mem_addr = `PIF_JUMP_LOC;
				s_next.seq      = st_jump;
			end
			st_jump: begin
				s_next.seq = st_idle;
			end
		endcase

		// A fresh enable holds off interrupts for one more instruction
		if (!s_reg.cpu_irq_enable_flag && s_next.cpu_irq_enable_flag)
			s_next.defer = 1'b1;
		if (!s_next.cpu_irq_enable_flag)
			s_next.defer = 1'b0;
	end

	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	// Outputs straight from the state
	assign s_axi_bvalid     = s_reg.bvalid;
	assign s_axi_bresp      = s_reg.bresp;
	assign s_axi_rvalid     = s_reg.rvalid;
	assign s_axi_rresp      = s_reg.rresp;
	assign s_axi_rdata      = s_reg.rdata;
	assign dev_done_flag    = s_reg.done;
	assign dev_mask_flag    = s_reg.mask;
	assign irq_request_line = s_reg.req_line;
	assign irq_start        = s_reg.start;
	assign mem_we           = s_reg.mem_we;
	assign jump_indirect    = s_reg.jump;
	assign mem_addr         = s_reg.mem_addr;
	assign mem_wdata        = s_reg.mem_wdata;

endmodule : pif_top

// ==== testbench/pif_properties.sv ====
/* Port-level checker of the interrupt facility.
   Assumes it is bound into pif_top and shares its N. */
`timescale 1ns/1ps

module pif_properties #(
	parameter int N = 4
) (
	// Clock and resets
	input wire logic         aclk,
	input wire logic         aresetn,
	input wire logic         console_reset,
	// Inputs that cause events
	input wire logic         dch_pending,
	input wire logic [15:0]  next_pc,
	input wire logic [N-1:0] dev_done_set,
	// Watched outputs
	input wire logic [N-1:0] dev_done_flag,
	input wire logic [N-1:0] dev_mask_flag,
	input wire logic         irq_request_line,
	input wire logic         irq_start,
	input wire logic         mem_we,
	input wire logic         jump_indirect,
	input wire logic [15:0]  mem_addr,
	input wire logic [15:0]  mem_wdata
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Shared line follows unmasked done flags one cycle late
	a_req_line_or: assert property (
		irq_request_line == $past(|(dev_done_flag & ~dev_mask_flag))) else $error("bad request line");
	// Entry saves the next pc at location zero
	a_entry_save: assert property (
		irq_start |-> mem_we && mem_addr == 16'h0000 && mem_wdata == $past(next_pc))
		else $error("bad save cycle");
	a_entry_jump: assert property (
		irq_start |=> jump_indirect && !mem_we && mem_addr == 16'h0001) else $error("no jump");
	// Channel traffic must be drained before an entry
	a_chan_first: assert property (
		irq_start |-> !$past(dch_pending)) else $error("entry beside channel request");
	// Entry clears the enable, so no second start follows at once
	a_entry_once: assert property (
		irq_start |=> !irq_start [*2]) else $error("repeated entry");
	// Console reset clears masks and any done not set in that cycle
	a_console_clr: assert property (
		console_reset |=> dev_mask_flag == '0 && (dev_done_flag & ~$past(dev_done_set)) == '0)
		else $error("flags survive console reset");
	a_console_idle: assert property (
		console_reset |=> !irq_start) else $error("entry during console reset");
	a_done_sets: assert property (
		|dev_done_set |=> (dev_done_flag & $past(dev_done_set)) == $past(dev_done_set))
		else $error("done not set");
endmodule : pif_properties

bind pif_top pif_properties #(.N(N)) u_pif_props (.*);

// ==== testbench/pif_periph_model.sv ====
/* Behavioural peripheral controllers on the shared bus.
   Assumes one-cycle start pulses from the bench. */
`timescale 1ns/1ps

module pif_periph_model #(
	parameter int N   = 4,
	parameter int LAT = 40
) (
	// Clock and operation starts
	input wire logic         aclk,
	input wire logic [N-1:0] go,
	// Flag pulses into the facility
	output logic     [N-1:0] busy_set,
	output logic     [N-1:0] done_set
);
	int cnt [N];

	initial begin
		busy_set = '0;
		done_set = '0;
	end

	// Busy on start, done once the operation time runs out
	always @(posedge aclk) begin
		for (int i = 0; i < N; i++) begin
			busy_set[i] <= go[i];
			done_set[i] <= (cnt[i] == 1);
			if (go[i])
				cnt[i] <= LAT;
			else if (cnt[i] > 0)
				cnt[i] <= cnt[i] - 1;
		end
	end
endmodule : pif_periph_model

// ==== testbench/test_program_interrupt_facility.sv ====
/* Self-checking bench of the interrupt facility.
   Assumes the register map and entry timing of the hand-over. */
`timescale 1ns/1ps

module test_program_interrupt_facility;
	typedef struct {logic [7:0] wa; logic [31:0] wd; logic [7:0] ra; logic [31:0] ex;} pif_row_t;
	localparam int          N     = 4;
	localparam logic [23:0] CODES = {6'h13, 6'h12, 6'h11, 6'h10};
	localparam logic [15:0] MBITS = {4'h5, 4'h0, 4'h9, 4'h2};
	logic aclk, aresetn, console_reset, insn_end, dch_pending, irq_request_line;
	logic irq_start, mem_we, jump_indirect, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic [7:0]   s_axi_awaddr, s_axi_araddr;
	logic [31:0]  s_axi_wdata, s_axi_rdata;
	logic [3:0]   s_axi_wstrb;
	logic [1:0]   s_axi_bresp, s_axi_rresp, rsp;
	logic [N-1:0] go, dev_done_set, dev_busy_set, dev_done_flag, dev_mask_flag;
	logic [15:0]  next_pc, mem_addr, mem_wdata;
	int           error_cnt, checks_done, cyc, starts, k;
	pif_row_t     rows [8];

	pif_top #(.N(N), .DEV_CODE_LIST(CODES), .MASK_BIT_LIST(MBITS)) DUT (.*);
	pif_periph_model #(.N(N)) u_periph (.aclk(aclk), .go(go), .busy_set(dev_busy_set),
		.done_set(dev_done_set));

	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	// Cycle ceiling and count of interrupt entries
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		starts <= starts + (irq_start === 1'b1);
		if (cyc == 5000) begin
			error_cnt++;
			end_sim();
		end
	end

	function automatic logic [31:0] mw(input logic [N-1:0] m);
		logic [31:0] w;
		w = '0;
		for (int i = 0; i < N; i++)
			if (m[i])
				w[15 - MBITS[i*4 +: 4]] = 1'b1;
		return w;
	endfunction : mw

	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask : tick

	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		checks_done++;
		if (got !== ex) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
			error_cnt++;
		end
	endtask : chk

	// Both write channels offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		// Ends on bvalid; the cycle ceiling ends a hung wait
		forever begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid)
				break;
		end
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr

	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] ex);
		@(posedge aclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		forever begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid)
				break;
		end
		s_axi_rready <= 1'b0;
		chk(nm, ex, s_axi_rdata);
		chk("rresp", (a > 8'h18) ? 2'h2 : 2'h0, s_axi_rresp);
	endtask : rchk

	task automatic op(input int i);
		go[i] <= 1'b1;
		@(posedge aclk);
		go[i] <= 1'b0;
		for (k = 0; k < 99 && dev_done_flag[i] !== 1'b1; k++)
			@(posedge aclk);
		tick(2);
	endtask : op

	task automatic pulse_end;
		insn_end <= 1'b1;
		@(posedge aclk);
		insn_end <= 1'b0;
		@(posedge aclk);
	endtask : pulse_end

	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_sim

	initial begin
		{aresetn, console_reset, insn_end, dch_pending, go, error_cnt, checks_done} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, next_pc, cyc, starts} = '0;
		s_axi_wstrb = 4'hf;
		rows = '{'{8'h00, 32'h10000, 8'h00, 32'h3}, '{8'h00, 32'h20000, 8'h00, 32'h0},
			'{8'h04, mw(4'h5), 8'h04, 32'h5}, '{8'h04, mw(4'ha) | 32'h10000, 8'h00, 32'h3},
			'{8'h04, mw(4'ha) | 32'h20000, 8'h04, 32'ha}, '{8'h08, 32'hffff, 8'h08, 32'h0},
			'{8'h40, 32'h10000, 8'h00, 32'h0}, '{8'h04, 32'h0, 8'h04, 32'h0}};
		tick(5);
		aresetn <= 1'b1;
		foreach (rows[i]) begin
			wr(rows[i].wa, rows[i].wd);
			chk("bresp", (rows[i].wa > 8'h18) ? 2'h2 : 2'h0, rsp);
			rchk("row read", rows[i].ra, rows[i].ex);
		end
		// An empty strobe answers but leaves the enable alone
		s_axi_wstrb <= 4'h0;
		wr(8'h00, 32'h10000);
		s_axi_wstrb <= 4'hf;
		chk("strobe bresp", 32'h0, rsp);
		rchk("no strobe", 8'h00, 32'h0);
		rchk("bad read", 8'h40, 32'h0);
		$display("test rows done");
		// Masking withholds and acknowledge follows bus order
		op(2);
		chk("line up", 1, irq_request_line);
		rchk("ack p2", 8'h08, CODES[12 +: 6]);
		wr(8'h04, mw(4'h4));
		// The shared line trails the mask flags by one edge
		tick(1);
		chk("line masked", 0, irq_request_line);
		rchk("done masked", 8'h10, 32'h4);
		rchk("ack masked", 8'h08, 32'h0);
		op(1);
		wr(8'h04, 32'h0);
		rchk("req unmasked", 8'h18, 32'h6);
		rchk("ack order", 8'h08, CODES[6 +: 6]);
		chk("line unmasked", 1, irq_request_line);
		pulse_end();
		// Let a wrongly started entry reach the counter
		tick(2);
		chk("ion off", 0, starts);
		$display("test flags done");
		// Entry waits one instruction after enabling, then for the channel
		wr(8'h00, 32'h10000);
		next_pc <= 16'h1234;
		pulse_end();
		tick(3);
		chk("defer", 0, starts);
		dch_pending <= 1'b1;
		pulse_end();
		tick(4);
		chk("held", 0, starts);
		dch_pending <= 1'b0;
		for (k = 0; k < 20 && irq_start !== 1'b1; k++)
			@(posedge aclk);
		chk("saved pc", 32'h1234, mem_wdata);
		rchk("ion cleared", 8'h00, 32'h0);
		wr(8'h00, 32'h10000);
		pulse_end();
		pulse_end();
		tick(3);
		chk("again", 2, starts);
		wr(8'h10, 32'hf);
		rchk("done clear", 8'h10, 32'h0);
		$display("test entry done");
		// Bus reset clears flags, then applies the start command
		go[3] <= 1'b1;
		@(posedge aclk);
		go[3] <= 1'b0;
		rchk("busy", 8'h14, 32'h8);
		wr(8'h04, mw(4'hf));
		wr(8'h0c, 32'h10000);
		rchk("busy clr", 8'h14, 32'h0);
		rchk("mask clr", 8'h04, 32'h0);
		rchk("ion set", 8'h00, 32'h3);
		wr(8'h04, mw(4'h3));
		console_reset <= 1'b1;
		@(posedge aclk);
		console_reset <= 1'b0;
		rchk("console ion", 8'h00, 32'h0);
		rchk("console mask", 8'h04, 32'h0);
		$display("test resets done");
		// Second reset in mid-run
		wr(8'h04, mw(4'hc));
		aresetn <= 1'b0;
		tick(5);
		aresetn <= 1'b1;
		rchk("reset mask", 8'h04, 32'h0);
		rchk("reset ion", 8'h00, 32'h0);
		$display("test power reset done");
		end_sim();
	end
endmodule : test_program_interrupt_facility
